// *** wd_counter.sv ***
// Fixed-length watchdog counter with restart and overflow pulse.
// Assumes restart is a one-cycle or level request from the parent.
`timescale 1ns/1ps
module wd_counter import wdt_pkg::*; #(
  parameter int unsigned TIMEOUT = TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  output logic overflow
);

  localparam int unsigned CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

  // Refuse a limit too short for the counter to reach its last value
  if (TIMEOUT < 2) begin : g_bad_timeout
    $error("wd_counter: TIMEOUT must be at least 2");
  end

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic ovf_q;
  logic ovf_d;

  // Next count: restart from zero, otherwise count up to the limit
  always_comb begin
    count_d = count_q;
    ovf_d = 1'b0;
    if (restart) begin
      count_d = '0;
    end else if (count_q == LAST) begin
      count_d = '0;
      ovf_d = 1'b1;
    end else begin
      count_d = count_q + CW'(1);
    end
  end

  // Counter registers
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ovf_q <= ovf_d;
    end
  end

  assign overflow = ovf_q;

endmodule

// *** wdt_pkg.sv ***
// Package for the hardware watchdog and shared interrupt flag block.
// Assumes a 125 MHz processor clock and a synchronous register port.
package wdt_pkg;

  // Clock rate and watchdog timeout
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TIMEOUT_MS = 1500;
  localparam longint unsigned TIMEOUT_CYC_L =
    (longint'(CLK_HZ) * longint'(TIMEOUT_MS)) / 64'd1000;
  localparam int unsigned TIMEOUT_CYC = int'(TIMEOUT_CYC_L);

  // Length of the processor reset pulse after an overflow
  localparam int unsigned PROC_RST_CYC = 16;

  // Register offset and field positions
  localparam logic [7:0] WD_REG_ADDR = 8'hE8;
  localparam int unsigned RTC_BIT = 0;
  localparam int unsigned XFER_BIT = 1;
  localparam int unsigned OVF_BIT = 2;
  localparam int unsigned REFRESH_BIT = 7;

  // Values after reset
  localparam logic RTC_FLAG_RST = 1'b0;
  localparam logic XFER_FLAG_RST = 1'b0;
  localparam logic OVF_FLAG_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } wd_state_t;

endpackage

// *** wdt_shared_irq.sv ***
// Hardware watchdog with overflow flag and shared RTC/transfer interrupt.
// Function
// - Writing one to bit 7 refreshes watchdog
// - Timeout is fixed, not software changeable
// - No register write can stop the watchdog
// - Overflow resets processor like the reset pin
// - Overflow sets flag surviving the processor reset
// - Overflow flag cleared only by reset pin
// - Flags OR-ed; interrupt on rising edge only
// - Transfer flag set at each accumulation end
// Assumes a byte-wide special-function register port in the clock domain;
// SYS_RST stands for the external active-low reset pin being held low.
`timescale 1ns/1ps
module wdt_shared_irq import wdt_pkg::*; #(
  parameter int unsigned TIMEOUT = TIMEOUT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  input wire logic RTC_SECOND_EVT,
  input wire logic XFER_DONE_EVT,
  output logic [7:0] SFR_RDATA,
  output logic PROC_RST,
  output logic WATCHDOG_OVERFLOW_FLAG,
  output logic RTC_SECOND_IRQ_FLAG,
  output logic TRANSFER_DONE_IRQ_FLAG,
  output logic SHARED_EXTERNAL_IRQ
);

  localparam int unsigned HW = $clog2(PROC_RST_CYC + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(PROC_RST_CYC - 1);

  // Refuse a timeout too short for the counter to reach its last value;
  // the check runs at elaboration so a bad build never starts
  if (TIMEOUT < 2) begin : g_bad_timeout
    $error("wdt_shared_irq: TIMEOUT must be at least 2");
  end

  // Register port decode
  logic reg_wr;
  logic reg_rd;
  logic refresh;
  assign reg_wr = SFR_WR && (SFR_ADDR == WD_REG_ADDR);
  assign reg_rd = SFR_RD && (SFR_ADDR == WD_REG_ADDR);
  // Only the refresh bit of a write restarts the count
  assign refresh = reg_wr && SFR_WDATA[REFRESH_BIT];

  // Watchdog counter; limit is an elaboration constant only
  logic watchdog_overflow_flag;
  logic wd_restart;
  wd_counter #(
    .TIMEOUT(TIMEOUT)
  ) u_counter (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .restart(wd_restart),
    .overflow(watchdog_overflow_flag)
  );

  // Reset sequencer state
  wd_state_t state_q;
  wd_state_t state_d;
  logic [HW-1:0] hold_q;
  logic [HW-1:0] hold_d;
  logic proc_rst_q;
  logic proc_rst_d;

  // Overflow drives a processor reset pulse of fixed length
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    proc_rst_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (watchdog_overflow_flag) begin
          state_d = ST_HOLD;
          hold_d = '0;
          proc_rst_d = 1'b1;
        end
      end
      ST_HOLD: begin
        if (hold_q == HOLD_LAST) begin
          state_d = ST_RUN;
        end else begin
          hold_d = hold_q + HW'(1);
          proc_rst_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Counter keeps running; it only restarts on refresh or processor reset.
  // Restarting during the pulse keeps a second expiry from stacking on it.
  assign wd_restart = refresh || proc_rst_q;

  // Sequencer registers
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q <= ST_RUN;
      hold_q <= '0;
      proc_rst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      proc_rst_q <= proc_rst_d;
    end
  end

  // Overflow flag state
  logic ovf_q;
  logic ovf_d;
  // Shared interrupt edge detector state
  logic comb_q;
  logic comb_d;
  logic irq_q;
  logic irq_d;
  // Read data state
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  // Event flag state, bit 0 one-second flag, bit 1 transfer flag
  localparam int unsigned NFLAG = 2;
  localparam logic [NFLAG-1:0] FLAG_RST = {XFER_FLAG_RST, RTC_FLAG_RST};
  logic [NFLAG-1:0] evt;
  logic [NFLAG-1:0] clr;
  logic [NFLAG-1:0] flag_q;
  logic [NFLAG-1:0] flag_d;

  // Event inputs, one per flag
  assign evt[0] = RTC_SECOND_EVT;
  assign evt[1] = XFER_DONE_EVT;
  // A zero written to a flag's bit clears it; a one leaves it alone
  assign clr[0] = reg_wr && !SFR_WDATA[RTC_BIT];
  assign clr[1] = reg_wr && !SFR_WDATA[XFER_BIT];

  // One flag per source; an event wins over a clear in the same cycle,
  // so an event arriving during the handler's clearing write is not lost
  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    // Next flag value
    always_comb begin
      flag_d[i] = flag_q[i];
      if (clr[i]) begin
        flag_d[i] = 1'b0;
      end
      if (evt[i]) begin
        flag_d[i] = 1'b1;
      end
    end
    // Flag register, cleared by the pin reset
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        flag_q[i] <= FLAG_RST[i];
      end else begin
        flag_q[i] <= flag_d[i];
      end
    end
  end

  // Overflow flag: set by an expiry, untouched by writes and by the
  // processor reset, so firmware can see why it restarted
  always_comb begin
    ovf_d = ovf_q || watchdog_overflow_flag;
  end

  // Shared request fires only on the rising edge of the OR of both flags;
  // a flag left set hides a later set of the other one
  always_comb begin
    comb_d = |flag_d;
    irq_d = comb_d && !comb_q;
  end

  // Read data is captured on a read of the register and held until the next
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = 8'h00;
      rdata_d[RTC_BIT] = flag_q[0];
      rdata_d[XFER_BIT] = flag_q[1];
      rdata_d[OVF_BIT] = ovf_q;
    end
  end

  // Overflow, edge detector and read registers; only the pin reset
  // clears the overflow flag
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ovf_q <= OVF_FLAG_RST;
      comb_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= RDATA_RST;
    end else begin
      ovf_q <= ovf_d;
      comb_q <= comb_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign SFR_RDATA = rdata_q;
  assign PROC_RST = proc_rst_q;
  assign WATCHDOG_OVERFLOW_FLAG = ovf_q;
  assign RTC_SECOND_IRQ_FLAG = flag_q[0];
  assign TRANSFER_DONE_IRQ_FLAG = flag_q[1];
  assign SHARED_EXTERNAL_IRQ = irq_q;

endmodule

// *** wdt_shared_irq_properties.sv ***
// Checker for the watchdog and shared interrupt block.
// Assumes one clock domain with a sync active-high reset.
`timescale 1ns/1ps
module wdt_chk import wdt_pkg::*; #(
  parameter int unsigned TIMEOUT = TIMEOUT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic XFER_DONE_EVT,
  input wire logic PROC_RST,
  input wire logic WATCHDOG_OVERFLOW_FLAG,
  input wire logic RTC_SECOND_IRQ_FLAG,
  input wire logic TRANSFER_DONE_IRQ_FLAG,
  input wire logic SHARED_EXTERNAL_IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // Cycles since the last refresh, reset or processor reset
  wire rf = SFR_WR && SFR_ADDR == WD_REG_ADDR && SFR_WDATA[REFRESH_BIT];
  int unsigned idle_q, idle_d;
  always_comb idle_d = (SYS_RST || rf || PROC_RST) ? 0 : idle_q + 1;
  always_ff @(posedge SYS_CLK) idle_q <= idle_d;
  property p_tmo;
    $rose(PROC_RST) |-> idle_q inside {[TIMEOUT-2:TIMEOUT+4]};
  endproperty
  a_tmo: assert property (p_tmo) else $error("bad expiry");
  property p_cap; idle_q <= TIMEOUT + 4; endproperty
  a_cap: assert property (p_cap) else $error("no expiry");
  property p_len;
    $rose(PROC_RST) |-> PROC_RST [*8] ##1 PROC_RST [*8] ##1 !PROC_RST;
  endproperty
  a_len: assert property (p_len) else $error("bad pulse");
  property p_ovf; $rose(PROC_RST) |-> WATCHDOG_OVERFLOW_FLAG; endproperty
  a_ovf: assert property (p_ovf) else $error("no flag");
  property p_cause;
    $rose(WATCHDOG_OVERFLOW_FLAG) |-> $rose(PROC_RST);
  endproperty
  a_cause: assert property (p_cause) else $error("stray flag");
  property p_keep;
    WATCHDOG_OVERFLOW_FLAG |=> WATCHDOG_OVERFLOW_FLAG;
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_irq;
    SHARED_EXTERNAL_IRQ == $rose(RTC_SECOND_IRQ_FLAG ||
      TRANSFER_DONE_IRQ_FLAG);
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_xfer; XFER_DONE_EVT |=> TRANSFER_DONE_IRQ_FLAG; endproperty
  a_xfer: assert property (p_xfer) else $error("no xfer");
  // Main scenarios reached
  cover property ($rose(PROC_RST));
  cover property (SHARED_EXTERNAL_IRQ);
  cover property (rf);
endmodule
bind wdt_shared_irq wdt_chk #(.TIMEOUT(TIMEOUT)) chk_u (.*);

// *** wdt_shared_irq_tb.sv ***
// Bench for the watchdog and shared interrupt block.
// Assumes a short 50-cycle timeout for simulation.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  fail_count++; $display("wrong value %0t %h %h", $time, a, e); end end
module wdt_shared_irq_tb import wdt_pkg::*;;
  logic SYS_CLK = 0, SYS_RST = 1, SFR_WR = 0, SFR_RD = 0, pend = 0;
  logic RTC_SECOND_EVT = 0, XFER_DONE_EVT = 0, PROC_RST;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
  logic WATCHDOG_OVERFLOW_FLAG, RTC_SECOND_IRQ_FLAG;
  logic TRANSFER_DONE_IRQ_FLAG, SHARED_EXTERNAL_IRQ;
  logic [7:0] exp_q[$];
  logic [31:0] rnd = 32'hBEA6B49F;
  int fail_count = 0, total_checks = 0, irq_cnt = 0;
  logic [7:0] exp_r;
  wdt_shared_irq #(.TIMEOUT(50)) dut_u (.*);
  initial forever #4 SYS_CLK = ~SYS_CLK;
  // Compare each read answer with the oldest note
  always @(posedge SYS_CLK) pend <= SFR_RD && SFR_ADDR == WD_REG_ADDR;
  always @(negedge SYS_CLK) if (pend) begin
    exp_r = exp_q.pop_front();
    `CHK(SFR_RDATA, exp_r)
  end
  // Count shared interrupt pulses
  always @(posedge SYS_CLK) if (SHARED_EXTERNAL_IRQ === 1'b1) irq_cnt++;
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge SYS_CLK);
  endtask
  // Register write, read and event pulse
  task automatic wr(logic [7:0] a, logic [7:0] d);
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    SFR_WR <= 1;
    tick();
    SFR_WR <= 0;
    tick();
  endtask
  task automatic rd(logic [7:0] e);
    exp_q.push_back(e);
    SFR_ADDR <= WD_REG_ADDR;
    SFR_RD <= 1;
    tick();
    SFR_RD <= 0;
    tick();
  endtask
  task automatic ev(logic [1:0] x);
    {XFER_DONE_EVT, RTC_SECOND_EVT} <= x;
    tick();
    {XFER_DONE_EVT, RTC_SECOND_EVT} <= 2'b00;
    tick();
  endtask
  task automatic give_verdict();
    $display("checks %0d wrong %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    int n;
    tick(8);
    SYS_RST <= 0;
    tick();
    rd(8'h00);
    ev(2'b01);
    rd(8'h01);
    `CHK(irq_cnt, 1)
    ev(2'b10);
    rd(8'h03);
    `CHK(irq_cnt, 1)
    wr(WD_REG_ADDR, 8'h83);
    rd(8'h03);
    wr(WD_REG_ADDR, 8'h80);
    rd(8'h00);
    ev(2'b11);
    rd(8'h03);
    `CHK(irq_cnt, 2)
    `CHK({TRANSFER_DONE_IRQ_FLAG, RTC_SECOND_IRQ_FLAG}, 2'b11)
    wr(WD_REG_ADDR, 8'h82);
    rd(8'h02);
    wr(WD_REG_ADDR, 8'h80);
    rd(8'h00);
    $display("flag test done");
    repeat (6) begin
      rnd = nx(rnd);
      wr(rnd[7:0] == WD_REG_ADDR ? 8'h00 : rnd[7:0],
        rnd[15:8] | 8'h80);
      wr(WD_REG_ADDR, rnd[23:16] & 8'h7F | 8'h03);
    end
    n = 0;
    while (PROC_RST !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    `CHK(PROC_RST, 1'b1)
    `CHK(WATCHDOG_OVERFLOW_FLAG, 1'b1)
    tick(20);
    wr(WD_REG_ADDR, 8'h83);
    rd(8'h04);
    repeat (4) begin
      tick(40);
      wr(WD_REG_ADDR, 8'h83);
    end
    `CHK(PROC_RST, 1'b0)
    SYS_RST <= 1;
    tick(2);
    SYS_RST <= 0;
    tick();
    rd(8'h00);
    $display("watchdog test done");
    give_verdict();
  end
endmodule
